// File: ras_pkg.sv
/*
 * ras_pkg: constants and carrier types of the return-address stack.
 * assumes: 32-bit apb, one clock domain, byte addresses on paddr.
 */
package ras_pkg;

   localparam int          DEPTH       = 16;
   localparam int          PC_W        = 15;
   localparam int          PTR_W       = 5;
   localparam int          ADDR_W      = 8;
   localparam int          DATA_W      = 32;

   localparam logic [4:0]  PTR_EMPTY   = 5'h1F;
   localparam logic [4:0]  PTR_FULL    = 5'h0F;

   localparam logic [7:0]  OFF_PTR     = 8'h00;
   localparam logic [7:0]  OFF_TOS_LO  = 8'h04;
   localparam logic [7:0]  OFF_TOS_HI  = 8'h08;
   localparam logic [7:0]  OFF_STATUS  = 8'h0C;
   localparam logic [7:0]  OFF_MASK    = 8'h10;

   localparam int          BIT_OVF     = 0;
   localparam int          BIT_UNF     = 1;
   localparam logic [1:0]  STATUS_RST  = 2'h0;
   localparam logic [1:0]  MASK_RST    = 2'h0;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } ras_apb_req_type;

   typedef struct packed {
      logic              pready;
      logic              pslverr;
      logic [DATA_W-1:0] prdata;
   } ras_apb_rsp_type;

   typedef struct packed {
      logic            push;
      logic            pop;
      logic [PC_W-1:0] pc;
   } ras_seq_type;

endpackage : ras_pkg

// File: ras_seq_model.sv
/* ras_seq_model: instruction sequencer issuing push and pop pulses.
   assumes: driven only through its tasks, one pulse per call. */
`timescale 1ns/1ps
module ras_seq_model (
   input  wire logic                 sys_clk,
   output      ras_pkg::ras_seq_type seq
);
   initial seq = '0;

   task automatic push(input logic [14:0] pc);
      @(posedge sys_clk) seq <= '{1'h1, 1'h0, pc};
      // released pc goes to the inverse so a stale value is never seen
      @(posedge sys_clk) seq <= '{1'h0, 1'h0, ~pc};
   endtask : push

   task automatic pop();
      @(posedge sys_clk) seq <= '{1'h0, 1'h1, seq.pc};
      @(posedge sys_clk) seq <= '{1'h0, 1'h0, ~seq.pc};
   endtask : pop
endmodule : ras_seq_model

// File: ras_top.sv
/*
 * ras_top: sixteen-entry return-address stack with apb access,
 * overflow/underflow flags, interrupt and stack-error reset request.
 * assumes: sequencer gives push or pop one-cycle pulses; the error
 * reset enable is a static configuration level; synchronous inputs.
 */
// Implementation choices: the APB slave port and the address map.
// Overview of operation
// [RULE1] sixteen entries of fifteen-bit pc
// [RULE2] private storage, no memory address reaches
// [RULE3] calls and interrupts push the pc
// [RULE4] three return kinds pop the stack
// [RULE5] upper pc latch untouched by stack
// [RULE6] enable zero gives circular, no reset
// [RULE7] seventeenth push overwrites first entry
// [RULE8] flags set regardless of reset enable
// [RULE9] top-of-stack pair reads/writes pointed entry
// [RULE10] pointer write repositions top-of-stack pair
// [RULE11] pointer is five bits wide
// [RULE12] push increments, pop decrements pointer
// [RULE13] increment then write; read then decrement
// [RULE14] reset leaves pointer at 0x1F
// [RULE15] empty with enable reads zero
// [RULE16] enable one requests reset after flag
// [RULE17] pointer wraps modulo thirty-two
`timescale 1ns/1ps
module ras_top #(
   parameter int DEPTH = ras_pkg::DEPTH
) (
   input  wire logic                     sys_clk,
   input  wire logic                     sys_rst,
   input  wire logic                     clk_en,
   input  wire ras_pkg::ras_apb_req_type apb_req,
   output      ras_pkg::ras_apb_rsp_type apb_rsp,
   input  wire ras_pkg::ras_seq_type     seq,
   input  wire logic                     stack_error_reset_enable,
   output      logic [14:0]              pop_pc,
   output      logic                     pop_valid,
   output      logic                     stack_error_reset,
   output      logic                     irq
);

   // [RULE1] [RULE2] local array, only pointer-indexed
   logic [ras_pkg::PC_W-1:0]  stack_mem [DEPTH];
   // [RULE11] five-bit pointer
   logic [ras_pkg::PTR_W-1:0] stack_pointer;
   logic [1:0]                status;
   logic [1:0]                mask;
   // event register so the reset request follows the flag edge
   logic [1:0]                set_q;

   function automatic logic [3:0] slot(input logic [4:0] p);
      return p[3:0];
   endfunction : slot

   // apb decode
   wire logic       acc_end   = apb_req.psel & apb_req.penable & apb_rsp.pready;
   wire logic       wr_fire   = acc_end & apb_req.pwrite;
   wire logic [7:0] a         = apb_req.paddr;
   wire logic       hit_ptr   = (a == ras_pkg::OFF_PTR);
   wire logic       hit_lo    = (a == ras_pkg::OFF_TOS_LO);
   wire logic       hit_hi    = (a == ras_pkg::OFF_TOS_HI);
   wire logic       hit_stat  = (a == ras_pkg::OFF_STATUS);
   wire logic       hit_mask  = (a == ras_pkg::OFF_MASK);
   wire logic       mapped    = hit_ptr | hit_lo | hit_hi | hit_stat | hit_mask;

   // [RULE3] [RULE4] push has priority if both pulse
   wire logic       do_push   = seq.push;
   wire logic       do_pop    = seq.pop & ~seq.push;
   wire logic       empty     = (stack_pointer == ras_pkg::PTR_EMPTY);
   // [RULE8] flags independent of enable
   wire logic       ovf_ev    = do_push & (stack_pointer == ras_pkg::PTR_FULL);
   wire logic       unf_ev    = do_pop & empty;
   wire logic [1:0] set_bits  = {unf_ev, ovf_ev};

   // [RULE12] [RULE17] wraps mod 32 by width
   wire logic [4:0] ptr_inc   = stack_pointer + 5'h01;
   wire logic [4:0] ptr_dec   = stack_pointer - 5'h01;

   // [RULE9] [RULE15] pointed entry, zero when empty and enabled
   wire logic [14:0] tos      = (empty & stack_error_reset_enable) ? 15'h0000
                                : stack_mem[slot(stack_pointer)];

   wire logic [1:0]  clr_bits = (wr_fire & hit_stat) ? apb_req.pwdata[1:0] : 2'h0;
   // set wins over a simultaneous clear
   wire logic [1:0]  next_status = (status & ~clr_bits) | set_bits;
   wire logic [1:0]  next_mask   = (wr_fire & hit_mask) ? apb_req.pwdata[1:0] : mask;

   wire logic [31:0] rd_word =
        hit_ptr  ? {27'h0000000, stack_pointer} :
        hit_lo   ? {24'h000000, tos[7:0]}       :
        hit_hi   ? {25'h0000000, tos[14:8]}     :
        hit_stat ? {30'h00000000, status}       :
        hit_mask ? {30'h00000000, mask}         : 32'h00000000;

   // pointer: hardware events win over a software write
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         // [RULE14] empty after reset
         stack_pointer <= ras_pkg::PTR_EMPTY;
      end else if (clk_en) begin
         // [RULE12] [RULE13] increment on push, decrement after pop
         if (do_push) begin
            stack_pointer <= ptr_inc;
         end else if (do_pop) begin
            stack_pointer <= ptr_dec;
         end else if (wr_fire & hit_ptr) begin
            // [RULE10] reposition top-of-stack pair
            stack_pointer <= apb_req.pwdata[4:0];
         end
      end
   end

   // storage has no reset: contents undefined until written
   always_ff @(posedge sys_clk) begin
      if (clk_en) begin
         if (do_push) begin
            // [RULE13] [RULE7] pc goes to incremented slot
            stack_mem[slot(ptr_inc)] <= seq.pc;
         end else if (!do_pop && wr_fire && hit_lo) begin
            // [RULE9] software writes low byte
            stack_mem[slot(stack_pointer)][7:0] <= apb_req.pwdata[7:0];
         end else if (!do_pop && wr_fire && hit_hi) begin
            stack_mem[slot(stack_pointer)][14:8] <= apb_req.pwdata[6:0];
         end
      end
   end

   // [RULE5] pop returns pc only; no upper latch is touched here
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pop_pc    <= 15'h0000;
         pop_valid <= 1'b0;
      end else if (clk_en) begin
         pop_valid <= do_pop;
         if (do_pop) begin
            // [RULE13] read before the decrement
            pop_pc <= tos;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         status            <= ras_pkg::STATUS_RST;
         mask              <= ras_pkg::MASK_RST;
         irq               <= 1'b0;
         stack_error_reset <= 1'b0;
      end else if (clk_en) begin
         // [RULE8] sticky flags
         status            <= next_status;
         mask              <= next_mask;
         irq               <= |(next_status & next_mask);
         // [RULE16] [RULE6] reset one cycle after flag, only when enabled
         stack_error_reset <= stack_error_reset_enable & (|set_q);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         set_q <= 2'h0;
      end else if (clk_en) begin
         set_q <= set_bits;
      end
   end

   // two-cycle apb slave: ready in the second access cycle
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         apb_rsp <= '0;
      end else if (clk_en) begin
         apb_rsp.pready <= apb_req.psel & apb_req.penable & ~apb_rsp.pready;
         if (apb_req.psel & apb_req.penable & ~apb_rsp.pready) begin
            apb_rsp.pslverr <= ~mapped;
            apb_rsp.prdata  <= apb_req.pwrite ? 32'h00000000 : rd_word;
         end else begin
            apb_rsp.pslverr <= 1'b0;
            apb_rsp.prdata  <= 32'h00000000;
         end
      end
   end

   // assertions
   sequence s_push_at_full;
      clk_en && do_push && stack_pointer == 5'h0F;
   endsequence

   sequence s_pop_empty;
      clk_en && do_pop && stack_pointer == 5'h1F;
   endsequence

   // request is registered from set_q, so it shows two edges after the event
   property p_ovf_reset;
      @(posedge sys_clk) disable iff (sys_rst)
         s_push_at_full ##1 clk_en |=> stack_error_reset == stack_error_reset_enable;
   endproperty

   sequence s_apb_access;
      clk_en && apb_req.psel && apb_req.penable && !apb_rsp.pready;
   endsequence

   a_ptr_after_reset: assert property ( // [RULE14]
      @(posedge sys_clk) $past(sys_rst) |-> stack_pointer == 5'h1F)
      else $error("pointer not empty after reset");

   a_push_increments: assert property ( // [RULE12]
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && do_push |=> stack_pointer == $past(stack_pointer) + 5'h01)
      else $error("push did not increment pointer");

   a_pop_decrements: assert property ( // [RULE12] [RULE17]
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && do_pop |=> stack_pointer == $past(stack_pointer) - 5'h01)
      else $error("pop did not decrement pointer");

   a_push_then_pop: assert property ( // [RULE13]
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && do_push ##2 (clk_en && do_pop) |=> pop_valid && pop_pc == $past(seq.pc, 3))
      else $error("popped pc differs from pushed pc");

   a_ovf_flag_set: assert property ( // [RULE8]
      @(posedge sys_clk) disable iff (sys_rst) s_push_at_full |=> status[0])
      else $error("overflow flag not set");

   a_unf_flag_set: assert property ( // [RULE8]
      @(posedge sys_clk) disable iff (sys_rst) s_pop_empty |=> status[1])
      else $error("underflow flag not set");

   a_error_reset_req: assert property (p_ovf_reset) // [RULE16]
      else $error("stack error reset mismatch");

   a_circular_wrap: assert property ( // [RULE7]
      @(posedge sys_clk) disable iff (sys_rst)
         s_push_at_full |=> stack_pointer == 5'h10 && stack_mem[0] == $past(seq.pc))
      else $error("overflow push did not overwrite first entry");

   a_empty_tos_zero: assert property ( // [RULE15]
      @(posedge sys_clk) disable iff (sys_rst)
         stack_error_reset_enable && empty |-> tos == 15'h0000)
      else $error("empty stack read not zero");

   a_irq_level: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en |=> irq == |(status & mask))
      else $error("interrupt does not follow status and mask");

   // [RULE16] underflow reset request
   a_unf_reset_req: assert property ( // [RULE16]
      @(posedge sys_clk) disable iff (sys_rst)
         s_pop_empty ##1 clk_en |=> stack_error_reset == stack_error_reset_enable)
      else $error("underflow reset request mismatch");

   // [RULE6] circular mode never resets
   a_no_reset_circular: assert property ( // [RULE6]
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && !stack_error_reset_enable |=> !stack_error_reset)
      else $error("reset requested in circular mode");

   // [RULE13] popped value is the old top
   a_pop_reads_top: assert property ( // [RULE13]
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && do_pop |=> pop_valid && pop_pc == $past(tos))
      else $error("popped pc is not the old top entry");

   // [RULE13] push stores at the new pointer
   a_push_stores: assert property ( // [RULE13]
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && do_push |=> stack_mem[slot(stack_pointer)] == $past(seq.pc))
      else $error("pushed pc not at pointed entry");

   // [RULE12] pointer idle without events
   a_ptr_idle: assert property ( // [RULE12]
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && !do_push && !do_pop && !(wr_fire && hit_ptr) |=> $stable(stack_pointer))
      else $error("pointer moved without an event");

   // [RULE10] software pointer write
   a_ptr_write: assert property ( // [RULE10]
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && wr_fire && hit_ptr && !do_push && !do_pop
         |=> stack_pointer == $past(apb_req.pwdata[4:0]))
      else $error("pointer write not taken");

   // [RULE9] software writes top low byte
   a_tos_write_lo: assert property ( // [RULE9]
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && wr_fire && hit_lo && !do_push && !do_pop
         |=> stack_mem[slot(stack_pointer)][7:0] == $past(apb_req.pwdata[7:0]))
      else $error("top low byte write not taken");

   // [RULE9] top high byte read path
   a_read_tos_hi: assert property ( // [RULE9]
      @(posedge sys_clk) disable iff (sys_rst)
         s_apb_access ##0 (hit_hi && !apb_req.pwrite)
         |=> apb_rsp.prdata == {25'h0000000, $past(tos[14:8])})
      else $error("top high byte read mismatch");

   // [RULE11] pointer read path
   a_read_pointer: assert property ( // [RULE11]
      @(posedge sys_clk) disable iff (sys_rst)
         s_apb_access ##0 (hit_ptr && !apb_req.pwrite)
         |=> apb_rsp.prdata == {27'h0000000, $past(stack_pointer)})
      else $error("pointer read mismatch");

   // [RULE8] write one clears, checked with no flag event pending
   a_status_clear: assert property ( // [RULE8]
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && wr_fire && hit_stat && !ovf_ev && !unf_ev
         |=> (status & $past(apb_req.pwdata[1:0])) == 2'h0)
      else $error("status bits not cleared");

   a_mask_write: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && wr_fire && hit_mask |=> mask == $past(apb_req.pwdata[1:0]))
      else $error("mask write not taken");

   a_ready_answers: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
         s_apb_access |=> apb_rsp.pready)
      else $error("access not answered");

   a_ready_one_cycle: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && apb_rsp.pready |=> !apb_rsp.pready)
      else $error("ready held longer than one cycle");

   a_slverr_unmapped: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
         s_apb_access ##0 (!mapped) |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h00000000)
      else $error("unmapped access not refused");

   a_rdata_idle: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && !(apb_req.psel && apb_req.penable && !apb_rsp.pready)
         |=> apb_rsp.prdata == 32'h00000000 && !apb_rsp.pslverr)
      else $error("response not quiet outside an answer");

   // frozen state must not move while the enable is low
   a_freeze_state: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
         !clk_en |=> $stable(stack_pointer) && $stable(status) && $stable(irq))
      else $error("state moved while clock enable low");

   a_reset_outputs: assert property (
      @(posedge sys_clk)
         $past(sys_rst) |-> !irq && !pop_valid && !stack_error_reset && !apb_rsp.pready)
      else $error("outputs not quiet after reset");

endmodule : ras_top

// File: tb.sv
/* tb: apb and sequencer driven checks of the return-address stack.
   assumes: ras_top and ras_seq_model compiled, 250 MHz clock. */
`timescale 1ns/1ps
module tb;
   logic                     sys_clk = 1'h0;
   logic                     sys_rst = 1'h1;
   logic                     clk_en  = 1'h1;
   logic                     sere    = 1'h1;
   ras_pkg::ras_apb_req_type req     = '0;
   ras_pkg::ras_apb_rsp_type rsp;
   ras_pkg::ras_seq_type     seq;
   logic [14:0]              pop_pc;
   logic                     pop_valid;
   logic                     err_rst;
   logic                     irq;
   logic [14:0]              last_pop = 15'h0;
   logic [31:0]              rd;
   logic                     slverr;
   int                       rst_reqs = 0;
   int                       err_count = 0;
   int                       n_tests = 0;

   always #2 sys_clk = ~sys_clk;

   ras_seq_model SEQ (.sys_clk(sys_clk), .seq(seq));

   ras_top DUT (
      .sys_clk                  (sys_clk),
      .sys_rst                  (sys_rst),
      .clk_en                   (clk_en),
      .apb_req                  (req),
      .apb_rsp                  (rsp),
      .seq                      (seq),
      .stack_error_reset_enable (sere),
      .pop_pc                   (pop_pc),
      .pop_valid                (pop_valid),
      .stack_error_reset        (err_rst),
      .irq                      (irq)
   );

   always @(posedge sys_clk) begin
      if (pop_valid === 1'h1) last_pop <= pop_pc;
      if (err_rst === 1'h1) rst_reqs <= rst_reqs + 1;
   end

   function automatic logic [14:0] pv(input int i);
      return 15'(i * 32'h421 + 32'h55);
   endfunction : pv

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk) req <= '{1'h1, 1'h0, w, a, d};
      @(posedge sys_clk) req.penable <= 1'h1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (rsp.pready !== 1'h1 && n < 40);
      if (rsp.pready !== 1'h1) begin
         err_count++;
         $display("[ERR] pready expected 1 seen %b", rsp.pready);
      end
      rd = rsp.prdata;
      slverr = rsp.pslverr;
      req <= '0;
   endtask : apb

   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results

   initial begin
      #20000;
      err_count++;
      results();
   end

   initial begin
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'h0;
      apb(1'h0, 8'h00, 32'h0);
      chk("ptr_reset", 32'h1F, rd);
      apb(1'h0, 8'h04, 32'h0);
      chk("tos_lo_empty", 32'h0, rd);
      apb(1'h0, 8'h08, 32'h0);
      chk("tos_hi_empty", 32'h0, rd);
      apb(1'h0, 8'h14, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, slverr});
      chk("unmapped_rd", 32'h0, rd);
      SEQ.pop();
      repeat (4) @(posedge sys_clk);
      apb(1'h0, 8'h0C, 32'h0);
      chk("status_unf", 32'h2, rd);
      chk("reset_req", 32'h1, rst_reqs);
      apb(1'h1, 8'h0C, 32'h2);
      apb(1'h1, 8'h00, 32'h1F);
      sere <= 1'h0;
      // first push from empty lands on entry zero
      for (int i = 0; i < 16; i++) SEQ.push(pv(i));
      apb(1'h0, 8'h00, 32'h0);
      chk("ptr_full", 32'h0F, rd);
      apb(1'h1, 8'h10, 32'h3);
      SEQ.push(pv(16));
      repeat (3) @(posedge sys_clk);
      chk("irq_set", 32'h1, {31'h0, irq});
      apb(1'h0, 8'h0C, 32'h0);
      chk("status_ovf", 32'h1, rd);
      chk("reset_req", 32'h1, rst_reqs);
      apb(1'h1, 8'h0C, 32'h1);
      apb(1'h0, 8'h0C, 32'h0);
      chk("status_clr", 32'h0, rd);
      chk("irq_clr", 32'h0, {31'h0, irq});
      apb(1'h1, 8'h00, 32'h0);
      apb(1'h0, 8'h04, 32'h0);
      chk("tos_lo_wrap", 32'(pv(16) & 15'hFF), rd);
      apb(1'h0, 8'h08, 32'h0);
      chk("tos_hi_wrap", 32'(pv(16) >> 8), rd);
      apb(1'h1, 8'h00, 32'h0F);
      SEQ.pop();
      repeat (3) @(posedge sys_clk);
      chk("pop_pc", 32'(pv(15)), 32'(last_pop));
      apb(1'h0, 8'h00, 32'h0);
      chk("ptr_pop", 32'h0E, rd);
      apb(1'h1, 8'h00, 32'h3);
      apb(1'h1, 8'h04, 32'hAB);
      apb(1'h1, 8'h08, 32'h12);
      SEQ.pop();
      repeat (3) @(posedge sys_clk);
      chk("pop_tos_wr", 32'h12AB, 32'(last_pop));
      apb(1'h1, 8'h00, 32'h0);
      SEQ.pop();
      apb(1'h0, 8'h00, 32'h0);
      chk("ptr_wrap", 32'h1F, rd);
      SEQ.pop();
      repeat (3) @(posedge sys_clk);
      apb(1'h0, 8'h0C, 32'h0);
      chk("status_unf2", 32'h2, rd);
      chk("reset_req", 32'h1, rst_reqs);
      SEQ.push(15'h2A5C);
      SEQ.pop();
      repeat (3) @(posedge sys_clk);
      chk("push_pop_pc", 32'h2A5C, 32'(last_pop));
      results();
   end
endmodule : tb
